// ==== core/irs_pkg.sv ====
// Constants, types and the state record of the interrupt and reset sequencer.
// Assumes one clock; the oscillator cycle equals one aclk cycle.
package irs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the 8-bit register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IOPT = 8'hC8; // Interrupt option, write only
  localparam logic [7:0] ADDR_MASK = 8'hCC; // Peripheral masks
  localparam logic [7:0] ADDR_STAT = 8'hD0; // Sequencer status, read only
  localparam logic [7:0] IOPT_RST = 8'h00;

  // Interrupt option field positions
  localparam int GEN_BIT = 4;
  localparam int ESB_BIT = 5;
  localparam int LES_BIT = 6;

  // Mask register field positions
  localparam int M_TIMER = 0;
  localparam int M_CONV = 1;
  localparam int M_RL_OVF = 2;
  localparam int M_RL_CMP = 3;
  localparam int M_RL_EDGE = 4;
  localparam int M_SERIAL = 5;

  // Synchronised pin positions
  localparam int PIN_EXT = 0; // External reset, low active
  localparam int PIN_POR = 1; // Power-on detector, low active
  localparam int PIN_NMI = 2; // Non-maskable pin, falling edge
  localparam int PIN_AB = 3;  // Ports A and B, combined low active
  localparam int PIN_C = 4;   // Port C, edge selected by option

  // ----------------------------------------------------------------
  // Vectors and values loaded at reset
  // ----------------------------------------------------------------
  localparam logic [11:0] VEC_RST = 12'hFFE;
  localparam logic [11:0] VEC_NMI = 12'hFFC;
  localparam logic [11:0] VEC_1 = 12'hFF6;
  localparam logic [11:0] VEC_2 = 12'hFF4;
  localparam logic [11:0] VEC_3 = 12'hFF2;
  localparam logic [11:0] VEC_4 = 12'hFF0;
  localparam logic [7:0] TIMER_CNT_RST = 8'hFF;
  localparam logic [7:0] TIMER_PRESC_RST = 8'h7F;
  localparam logic [7:0] WDOG_CNT_RST = 8'hFE;
  localparam logic [7:0] CONV_CTRL_RST = 8'h40;
  localparam int DELAY_SHORT_CYC = 2048; // Reset release delay, oscillator cycles

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_NORM = 2'b00,
    LVL_IRQ = 2'b01,
    LVL_NMI = 2'b10
  } irs_level_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_RST_HOLD = 3'b001,
    ST_RST_DLY = 3'b010,
    ST_SWAP = 3'b011,
    ST_PUSH = 3'b100,
    ST_CLR = 3'b101,
    ST_VEC = 3'b110
  } irs_state_e_t;

  typedef struct packed {
    irs_state_e_t st;
    irs_level_t lvl;
    irs_level_t nmi_prev;      // Level to return to from the NMI routine
    logic [2:0][1:0] cz;       // Carry/zero bank per level
    logic [3:0][11:0] stk;     // Return stack, entry 0 is the top
    logic [2:0] sel;           // Accepted source, 0 is NMI
    logic waiting;
    logic ab_lat;
    logic c_lat;
    logic nmi_lat;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] flt;
    logic [15:0] cnt;
    logic [7:0] iopt;
    logic [5:0] mask;
    logic pc_ld;
    logic [11:0] pc_val;
    logic [4:0] ack;
    logic init;
    logic osc_rs;
    logic aw_got;
    logic w_got;
    logic wen;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } irs_state_t;

  localparam irs_state_t STATE_RST = '{st: ST_RST_HOLD, lvl: LVL_NORM, nmi_prev: LVL_NORM,
    s1: 5'h1F, s2: 5'h1F, s3: 5'h1F, flt: 5'h1F, default: '0};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Vector address of an accepted source
  function automatic logic [11:0] vec_of(input logic [2:0] sel);
    case (sel)
      3'h1: vec_of = VEC_1;
      3'h2: vec_of = VEC_2;
      3'h3: vec_of = VEC_3;
      3'h4: vec_of = VEC_4;
      default: vec_of = VEC_NMI;
    endcase
  endfunction

endpackage

// ==== core/irs_top.sv ====
// Interrupt entry/return sequencer and reset sequencer of a small 8-bit core.
// Assumes the instruction sequencer on aclk and an AXI4-Lite master for registers.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: NMI serviced with enable off, no wake
// RULE2: Three carry/zero banks, switched by hardware
// RULE3: Entry swaps flags to the entered level
// RULE4: Entry pushes PC onto return stack
// RULE5: Entry blocks maskable requests until return
// RULE6: Clear source latch, then load vector
// RULE7: Return restores flags and pops PC
// RULE8: Global enable gates all but NMI; vector four
// RULE9: Reload timer three flags on vector three
// RULE10: Serial and port C vector two; A/B one
// RULE11: Reset from pin, power-on or watchdog
// RULE12: Internal reset is delayed pin reset
// RULE13: Reset in run/wait halts, pulls up I/O
// RULE14: Reset in stop restarts oscillator
// RULE15: Release delay 2048 or 32768 cycles
// RULE16: Power-up holds reset until delay elapsed
// RULE17: Watchdog reset reinitialises watchdog, same delay
// RULE18: Reset clears stack, loads reset vector
// RULE19: Start in NMI mode; return enables interrupts
// RULE20: Peripheral reset values loaded at reset
// RULE21: Wait halts core, peripherals keep running
// RULE22: Requests tested only at instruction end
// RULE23: Fixed priority, one highest, no nesting
// RULE24: Edge latches store one request each
// RULE25: Reset aborts entry without pushing
// RULE26: Software polls shared flags, saves registers
module irs_top import irs_pkg::*; #(
  parameter bit LONG_DELAY = 1'b0,     // Selects the long release delay
  parameter int DELAY_LONG_CYC = 32768 // Long delay, oscillator cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset_n,
  input wire logic por_n,
  input wire logic nmi_n,
  input wire logic port_ab_n,
  input wire logic port_c,
  input wire logic wdog_expire,
  input wire logic stop_mode,
  input wire logic instr_end,
  input wire logic return_from_irq_instr,
  input wire logic wait_instr,
  input wire logic [11:0] pc_in,
  input wire logic flag_we,
  input wire logic c_in,
  input wire logic z_in,
  input wire logic timer_overflow_flag,
  input wire logic converter_end_flag,
  input wire logic reload_timer_overflow_flag,
  input wire logic reload_timer_compare_flag,
  input wire logic reload_timer_edge_flag,
  input wire logic serial_done_flag,
  output logic core_reset,
  output logic core_halt,
  output logic io_pullup,
  output logic wdog_reinit,
  output logic osc_restart,
  output logic pc_load,
  output logic [11:0] pc_value,
  output logic c_out,
  output logic z_out,
  output logic [1:0] level,
  output logic [4:0] irq_ack,
  output logic periph_init,
  output logic [7:0] timer_count_init,
  output logic [7:0] timer_presc_init,
  output logic [7:0] wdog_count_init,
  output logic [7:0] conv_ctrl_init
);

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  localparam int DLY_CYC = LONG_DELAY ? DELAY_LONG_CYC : DELAY_SHORT_CYC;
  localparam logic [15:0] DLY_LAST = 16'(DLY_CYC - 1);

  irs_state_t s_reg; // Whole state of the block
  irs_state_t s_next;
  logic [4:0] flt_new; // Filtered pins after this edge
  logic [4:0] fell;
  logic [4:0] rose;
  logic src;           // Any reset source active
  logic gen;           // Global enable
  logic [4:1] vreq;    // Requests per maskable vector
  logic mreq;          // Maskable request may be taken
  logic nreq;          // NMI request may be taken
  logic wake;
  logic [2:0] sel_m;   // Highest pending maskable vector
  logic in_entry;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // A pin change counts once the second and third stage agree
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      flt_new[i] = (s_reg.s2[i] == s_reg.s3[i]) ? s_reg.s3[i] : s_reg.flt[i];
    end
  end
  assign fell = s_reg.flt & ~flt_new;
  assign rose = ~s_reg.flt & flt_new;
  // Watchdog pulse enters hold at once, then shares the pin delay
  assign src = ~s_reg.flt[PIN_EXT] | ~s_reg.flt[PIN_POR] | wdog_expire; // see RULE11 see RULE17
  assign gen = s_reg.iopt[GEN_BIT];
  // Level mode has no memory: the line must be low when sampled
  assign vreq[1] = s_reg.iopt[LES_BIT] ? ~s_reg.flt[PIN_AB] : s_reg.ab_lat; // see RULE10
  assign vreq[2] = s_reg.c_lat | (serial_done_flag & s_reg.mask[M_SERIAL]); // see RULE10
  assign vreq[3] = (reload_timer_overflow_flag & s_reg.mask[M_RL_OVF])
    | (reload_timer_compare_flag & s_reg.mask[M_RL_CMP])
    | (reload_timer_edge_flag & s_reg.mask[M_RL_EDGE]); // see RULE9
  assign vreq[4] = (timer_overflow_flag & s_reg.mask[M_TIMER])
    | (converter_end_flag & s_reg.mask[M_CONV]); // see RULE8
  // Maskable only from normal level, so maskable routines never nest
  assign mreq = gen & (s_reg.lvl == LVL_NORM) & (|vreq); // see RULE5 see RULE8 see RULE23
  assign nreq = s_reg.nmi_lat & (s_reg.lvl != LVL_NMI);
  // NMI wakes only with the global enable set
  assign wake = s_reg.waiting & gen & (s_reg.nmi_lat | (|vreq)); // see RULE1
  assign sel_m = vreq[1] ? 3'h1 : vreq[2] ? 3'h2 : vreq[3] ? 3'h3 : 3'h4; // see RULE23
  assign in_entry = (s_reg.st == ST_SWAP) | (s_reg.st == ST_PUSH) | (s_reg.st == ST_CLR)
    | (s_reg.st == ST_VEC);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.pc_ld = 1'b0;
    s_next.ack = '0;
    s_next.init = 1'b0;
    s_next.osc_rs = 1'b0;
    s_next.s1 = {port_c, port_ab_n, nmi_n, por_n, ext_reset_n};
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.flt = flt_new;
    unique case (s_reg.st)
      ST_RUN: begin
        if (return_from_irq_instr) begin
          // Pop and fall back to the level below
          s_next.pc_ld = 1'b1; // see RULE7
          s_next.pc_val = s_reg.stk[0];
          s_next.stk = {12'h000, s_reg.stk[3:1]};
          s_next.lvl = (s_reg.lvl == LVL_NMI) ? s_reg.nmi_prev : LVL_NORM; // see RULE19
        end else if (((instr_end & ~s_reg.waiting) | wake) & (nreq | mreq)) begin
          s_next.st = ST_SWAP; // see RULE22
          s_next.sel = nreq ? 3'h0 : sel_m; // see RULE1 see RULE23
        end
        if (wake) begin
          s_next.waiting = 1'b0;
        end
        if (wait_instr) begin
          s_next.waiting = 1'b1; // see RULE21
        end
      end
      ST_SWAP: begin
        // Changing level selects the carry/zero bank of the entered level
        s_next.lvl = (s_reg.sel == 3'h0) ? LVL_NMI : LVL_IRQ; // see RULE3 see RULE5
        if (s_reg.sel == 3'h0) begin
          s_next.nmi_prev = s_reg.lvl;
        end
        s_next.st = ST_PUSH;
      end
      ST_PUSH: begin
        s_next.stk = {s_reg.stk[2:0], pc_in}; // see RULE4
        s_next.st = ST_CLR;
      end
      ST_CLR: begin
        // Peripheral flags stay up; software polls and clears them
        unique case (s_reg.sel)
          3'h0: s_next.nmi_lat = 1'b0; // see RULE6 see RULE24
          3'h1: s_next.ab_lat = 1'b0;
          3'h2: s_next.c_lat = 1'b0;
          default: begin
          end
        endcase
        s_next.ack = 5'(1 << s_reg.sel);
        s_next.st = ST_VEC;
      end
      ST_VEC: begin
        s_next.pc_ld = 1'b1; // see RULE6
        s_next.pc_val = vec_of(s_reg.sel);
        s_next.st = ST_RUN;
      end
      ST_RST_HOLD: begin
        s_next.cnt = '0;
        if (!src) begin
          s_next.st = ST_RST_DLY; // see RULE12
        end
      end
      ST_RST_DLY: begin
        if (s_reg.cnt == DLY_LAST) begin
          // Initialisation: empty stack, reset vector, NMI level
          s_next.st = ST_RUN; // see RULE15 see RULE16
          s_next.stk = '0; // see RULE18
          s_next.pc_ld = 1'b1;
          s_next.pc_val = VEC_RST;
          s_next.lvl = LVL_NMI; // see RULE19
          s_next.nmi_prev = LVL_NORM;
          s_next.iopt = IOPT_RST; // see RULE20
          s_next.mask = '0;
          s_next.init = 1'b1;
          s_next.nmi_lat = 1'b0;
          s_next.ab_lat = 1'b0;
          s_next.c_lat = 1'b0;
        end else begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
      end
      default: begin
        s_next.st = ST_RST_HOLD;
      end
    endcase
    // Flags written by the core go to the bank of the active level
    if (flag_we && s_reg.st == ST_RUN) begin
      s_next.cz[s_reg.lvl] = {c_in, z_in}; // see RULE2
    end
    // Edge latches; a new edge wins over the clear of this cycle
    if (fell[PIN_NMI]) begin
      s_next.nmi_lat = 1'b1;
    end
    if (!s_reg.iopt[LES_BIT] && fell[PIN_AB]) begin
      s_next.ab_lat = 1'b1; // see RULE24
    end
    if (s_reg.iopt[ESB_BIT] ? rose[PIN_C] : fell[PIN_C]) begin
      s_next.c_lat = 1'b1; // see RULE24
    end
    // Reset has priority over the sequencer state, including a half-done entry
    if (src) begin
      s_next.st = ST_RST_HOLD; // see RULE13 see RULE25
      s_next.cnt = '0;
      s_next.waiting = 1'b0;
      s_next.pc_ld = 1'b0;
      s_next.stk = s_reg.stk;
      if (stop_mode && s_reg.st != ST_RST_HOLD) begin
        s_next.osc_rs = 1'b1; // see RULE14
      end
    end
    // Register bus: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wen = s_axi_wstrb[0];
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if (s_reg.awaddr == ADDR_IOPT) begin
        if (s_reg.wen) begin
          s_next.iopt = s_reg.wdata; // see RULE8
        end
      end else if (s_reg.awaddr == ADDR_MASK) begin
        if (s_reg.wen) begin
          s_next.mask = s_reg.wdata[5:0];
        end
      end else if (s_reg.awaddr != ADDR_STAT) begin
        s_next.bresp = RESP_SLVERR;
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = 8'h00;
      if (s_axi_araddr == ADDR_MASK) begin
        s_next.rdata = {2'b00, s_reg.mask};
      end else if (s_axi_araddr == ADDR_STAT) begin
        s_next.rdata = {vreq, core_reset, s_reg.waiting, s_reg.lvl};
      end else if (s_axi_araddr != ADDR_IOPT) begin
        s_next.rresp = RESP_SLVERR;
      end
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign core_reset = (s_reg.st == ST_RST_HOLD) | (s_reg.st == ST_RST_DLY); // see RULE16
  assign io_pullup = core_reset; // see RULE13
  assign wdog_reinit = core_reset; // see RULE17
  assign core_halt = core_reset | s_reg.waiting | in_entry; // see RULE21
  assign osc_restart = s_reg.osc_rs;
  assign pc_load = s_reg.pc_ld;
  assign pc_value = s_reg.pc_val;
  assign c_out = s_reg.cz[s_reg.lvl][1];
  assign z_out = s_reg.cz[s_reg.lvl][0];
  assign level = s_reg.lvl;
  assign irq_ack = s_reg.ack;
  assign periph_init = s_reg.init;
  assign timer_count_init = TIMER_CNT_RST; // see RULE20
  assign timer_presc_init = TIMER_PRESC_RST;
  assign wdog_count_init = WDOG_CNT_RST;
  assign conv_ctrl_init = CONV_CTRL_RST;
  assign s_axi_awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign s_axi_wready = ~s_reg.w_got & ~s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = ~s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = {24'h000000, s_reg.rdata};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence entry_steps;
    s_reg.st == ST_SWAP ##1 s_reg.st == ST_PUSH ##1 s_reg.st == ST_CLR ##1 s_reg.st == ST_VEC;
  endsequence

  reset_enter_a: assert property (src |=> s_reg.st == ST_RST_HOLD) // see RULE11
    else $error("reset source did not enter hold");
  reset_delay_a: assert property ($fell(core_reset) |-> $past(s_reg.cnt) == DLY_LAST) // see RULE15
    else $error("reset released before delay");
  reset_vec_a: assert property ($fell(core_reset) |-> pc_load && pc_value == VEC_RST) // see RULE18
    else $error("reset vector not loaded");
  reset_nmi_a: assert property ($fell(core_reset) |-> level == LVL_NMI && irq_ack == 5'h00) // see RULE19
    else $error("core not in NMI mode after reset");
  entry_order_a: assert property (disable iff (!aresetn || src)
    (s_reg.st == ST_RUN && s_next.st == ST_SWAP) |=> entry_steps ##1 pc_load) // see RULE6
    else $error("entry steps out of order");
  push_pc_a: assert property (s_reg.st == ST_PUSH && !src |=> s_reg.stk[0] == $past(pc_in)) // see RULE4
    else $error("program counter not pushed");
  entry_mask_a: assert property (s_reg.st == ST_PUSH |-> level != LVL_NORM && core_halt) // see RULE5
    else $error("maskable requests not blocked in entry");
  ack_vector_a: assert property (irq_ack != 5'h00 && !src |=> pc_load
    && pc_value == vec_of($past(s_reg.sel))) // see RULE6
    else $error("vector not loaded after clear");
  return_from_irq_instr_pop_a: assert property (s_reg.st == ST_RUN && return_from_irq_instr && !src
    |=> pc_load && pc_value == $past(s_reg.stk[0])) // see RULE7
    else $error("return did not pop the stack");
  wait_halt_a: assert property (s_reg.st == ST_RUN && wait_instr && !src
    |=> core_halt ##1 (core_halt || $past(wake))) // see RULE21
    else $error("wait did not halt the core");

endmodule
`default_nettype wire

// ==== testbench/irs_seq_model.sv ====
// Instruction sequencer stand-in: steps the program counter, pulses instr_end.
// Assumes the block's pc_load and core_halt on the same aclk.
`timescale 1ns/1ps
`default_nettype none
module irs_seq_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] step,
  input wire logic core_halt,
  input wire logic pc_load,
  input wire logic [11:0] pc_value,
  output logic instr_end,
  output logic [11:0] pc_in
);
  // One instruction every second cycle; frozen while halted so the pushed PC is known
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_end <= 1'h0;
      pc_in <= 12'h000;
    end else if (pc_load) begin
      instr_end <= 1'h0;
      pc_in <= pc_value;
    end else begin
      instr_end <= !instr_end && !core_halt;
      if (instr_end) pc_in <= pc_in + {8'h00, step} + 12'h001;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_interrupt_reset_sequencer.sv ====
// Self-checking bench of the interrupt and reset sequencer.
// Assumes irs_pkg and irs_top compiled first; release delay shortened to 64 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_reset_sequencer import irs_pkg::*;;
  // --------------------------------
  // Signals and expectation queue
  // --------------------------------
  typedef struct packed {logic care; logic [11:0] pc; logic [1:0] lvl;} irs_exp_t;
  irs_exp_t exp_q[$];
  irs_exp_t ex;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tci, tpi, wci, cci;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, level, cz;
  logic ext_reset_n = 1'h1, por_n = 1'h1, nmi_n = 1'h1, wdog_expire = 1'h0, stop_mode = 1'h0;
  logic return_from_irq_instr = 1'h0, flag_we = 1'h0, c_in = 1'h0, z_in = 1'h0, instr_end;
  logic wait_instr = 1'h0, port_ab_n = 1'h1; // Wait pulse and combined port A/B line
  logic [5:0] src = 6'h00; // Peripheral flags in mask-register order
  logic [3:0] step = 4'h0;
  logic core_reset, core_halt, io_pullup, wdog_reinit, osc_restart, pc_load, c_out, z_out, periph_init;
  logic [11:0] pc_value, pc_in, e1, e2;
  logic [4:0] irq_ack;
  logic osc_seen = 1'h0;
  logic [5:0] clr [0:4] = '{6'h00, 6'h00, 6'h20, 6'h1C, 6'h03}; // Flags behind each vector
  logic [11:0] vt [0:4] = '{VEC_NMI, VEC_1, VEC_2, VEC_3, VEC_4};
  int err_count = 0, total_checks = 0, acks = 0, waited, k, n;

  always #2 aclk = ~aclk;

  irs_top #(.LONG_DELAY(1'h1), .DELAY_LONG_CYC(64)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reset_n, .por_n, .nmi_n, .port_ab_n,
    .port_c(1'h0), .wdog_expire, .stop_mode, .instr_end, .return_from_irq_instr, .wait_instr,
    .pc_in, .flag_we, .c_in, .z_in, .timer_overflow_flag(src[0]), .converter_end_flag(src[1]),
    .reload_timer_overflow_flag(src[2]), .reload_timer_compare_flag(src[3]),
    .reload_timer_edge_flag(src[4]), .serial_done_flag(src[5]), .core_reset, .core_halt, .io_pullup,
    .wdog_reinit, .osc_restart, .pc_load, .pc_value, .c_out, .z_out, .level, .irq_ack, .periph_init,
    .timer_count_init(tci), .timer_presc_init(tpi), .wdog_count_init(wci), .conv_ctrl_init(cci));

  irs_seq_model model (.aclk, .aresetn, .step, .core_halt, .pc_load, .pc_value, .instr_end, .pc_in);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Each program counter load takes the oldest noted expectation
  always @(posedge aclk) begin
    if (pc_load === 1'h1) begin
      ex = exp_q.pop_front();
      if (ex.care) chk("pc_value", pc_value, ex.pc);
      chk("level", level, ex.lvl);
      chk("periph_init", periph_init, ex.pc == VEC_RST && ex.lvl == LVL_NMI);
    end
    if (irq_ack !== 5'h00) acks++;
    if (osc_restart === 1'h1) osc_seen = 1'h1;
  end

  // Bounded wait; waited keeps the cycle count for delay checks
  task automatic wait_for(input logic v, input string nm);
    for (waited = 0; waited < 500 && core_reset !== v; waited++) @(posedge aclk);
    if (core_reset !== v) chk(nm, core_reset, v);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    chk("write", {s_axi_bvalid, s_axi_bresp}, {1'h1, er});
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    chk("read", {s_axi_rvalid, s_axi_rresp, er === RESP_OKAY ? s_axi_rdata[7:0] : d}, {1'h1, er, d});
    @(posedge aclk);
  endtask

  // Return pulse; the popped PC and restored level are noted first
  task automatic ret(input logic care, input logic [11:0] pc, input logic [1:0] lv);
    exp_q.push_back('{care, pc, lv});
    return_from_irq_instr <= 1'h1;
    @(posedge aclk);
    return_from_irq_instr <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask

  // Wait for the one-hot acknowledge, note the pushed PC, drop that vector's flags
  task automatic take(input int v, output logic [11:0] e);
    for (n = 0; n < 60 && irq_ack === 5'h00; n++) @(posedge aclk);
    chk("irq_ack", irq_ack, 5'h01 << v);
    e = pc_in;
    src <= src & ~clr[v];
    repeat (4) @(posedge aclk);
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    void'($urandom(32'h2064));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    exp_q.push_back('{1'h1, VEC_RST, LVL_NMI});
    wait_for(1'h0, "core_reset");
    chk("inits", {tci, tpi, wci, cci}, 32'hFF7FFE40);
    axi_wr(ADDR_IOPT, 8'h10, RESP_OKAY);
    axi_rd(ADDR_IOPT, 8'h00, RESP_OKAY);
    axi_wr(ADDR_MASK, 8'h3F, RESP_OKAY);
    axi_rd(8'h40, 8'h00, RESP_SLVERR);
    axi_rd(ADDR_STAT, 8'h02, RESP_OKAY);
    ret(1'h0, 12'h000, LVL_NORM);
    cz = 2'($urandom);
    c_in <= cz[1];
    z_in <= cz[0];
    flag_we <= 1'h1;
    @(posedge aclk);
    flag_we <= 1'h0;
    exp_q.push_back('{1'h1, VEC_4, LVL_IRQ});
    src <= 6'h01;
    take(4, e1);
    src <= 6'h26;
    k = acks;
    repeat (30) @(posedge aclk);
    chk("nested", acks, k);
    for (k = 2; k <= 4; k++) begin
      step <= 4'($urandom);
      ret(1'h1, e1, LVL_NORM);
      exp_q.push_back('{1'h1, vt[k], LVL_IRQ});
      take(k, e1);
    end
    exp_q.push_back('{1'h1, VEC_NMI, LVL_NMI});
    nmi_n <= 1'h0;
    take(0, e2);
    nmi_n <= 1'h1;
    ret(1'h1, e2, LVL_IRQ);
    ret(1'h1, e1, LVL_NORM);
    chk("flags", {c_out, z_out}, cz);
    // Wait halts the core; a port A/B falling edge wakes it into vector one
    wait_instr <= 1'h1;
    @(posedge aclk);
    wait_instr <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("wait halt", {core_halt, instr_end}, 2'h2);
    exp_q.push_back('{1'h1, VEC_1, LVL_IRQ});
    port_ab_n <= 1'h0;
    take(1, e1);
    port_ab_n <= 1'h1;
    ret(1'h1, e1, LVL_NORM);
    for (k = 0; k < 3; k++) begin
      exp_q.push_back('{1'h1, VEC_RST, LVL_NMI});
      stop_mode <= (k == 0);
      ext_reset_n <= (k != 0);
      por_n <= (k != 1);
      wdog_expire <= (k == 2);
      @(posedge aclk);
      wdog_expire <= 1'h0;
      repeat (3) @(posedge aclk);
      ext_reset_n <= 1'h1;
      por_n <= 1'h1;
      wait_for(1'h1, "reset entry");
      stop_mode <= 1'h0;
      chk("reset outs", {io_pullup, wdog_reinit, core_halt}, 3'h7);
      wait_for(1'h0, "reset release");
      chk("delay", waited >= 60 && waited <= 72, 1'h1);
    end
    chk("osc restart", osc_seen, 1'h1);
    repeat (4) @(posedge aclk);
    chk("queue left", exp_q.size(), 0);
    print_verdict();
  end

  // Watchdog against a hang; the tests need about 500 cycles
  initial begin
    #40000;
    chk("timeout", 1'h0, 1'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
